// ==== wdt_params.svh ====
// Named constants of the I/O port watchdog timer.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ==========================================================================
// Port addresses
`define WDT_ADDR_DISABLE 16'h0080
`define WDT_ADDR_INTERVAL 16'h0443
`define WDT_ADDR_EVSEL 16'h0444

// ==========================================================================
// Fields and reset values
`define WDT_UNIT_BIT 7
`define WDT_INTERVAL_RST 8'h00
`define WDT_EVSEL_RST 3'h0
`define WDT_RDATA_IDLE 8'h00

// ==========================================================================
// Time-out event codes
`define WDT_SEL_RESET 3'h0
`define WDT_SEL_IRQ10 3'h1
`define WDT_SEL_IRQ15 3'h2
`define WDT_SEL_IRQ11 3'h3
`define WDT_SEL_NMI 3'h4

// ==========================================================================
// Timing
`define WDT_CLK_PERIOD_NS 50
`define WDT_TICK_PERIOD_NS 1000000000
`define WDT_TICK_CYCLES (`WDT_TICK_PERIOD_NS / `WDT_CLK_PERIOD_NS)
`define WDT_SEC_PER_MIN_LAST 6'h3b

`endif

// ==== wdt_pkg.sv ====
// Types shared by the watchdog timer modules.
`default_nettype none

package wdt_pkg;

	// ======================================================================
	// Host I/O access, one-cycle strobes on clk.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} wdt_io_req_t;

	// ======================================================================
	// Time-out actions, one-cycle pulses.
	typedef struct packed {
		logic sys_reset;
		logic irq10;
		logic irq15;
		logic irq11;
		logic nmi;
	} wdt_evt_t;

	typedef enum logic [1:0] {
		WDT_IDLE,
		WDT_RUN,
		WDT_EXPIRED
	} wdt_state_t;

endpackage : wdt_pkg

`default_nettype wire

// ==== wdt_tick_div.sv ====
// One-second tick divider for the watchdog timer.
`include "wdt_params.svh"
`default_nettype none

module wdt_tick_div #(
	parameter int TICK_CYCLES = `WDT_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	output logic tick
);

	localparam int W = $clog2(TICK_CYCLES);
	localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

	logic [W-1:0] cnt_r, cnt_nxt;
	logic tick_r, tick_nxt;

	// ======================================================================
	// Clearing restarts a full period so the first tick after arming is
	// never short.
	always_comb begin
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (clr) begin
			cnt_nxt = '0;
		end else if (cnt_r == LAST) begin
			cnt_nxt = '0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;

endmodule // wdt_tick_div

`default_nettype wire

// ==== wdt_io_watchdog.sv ====
// I/O port watchdog timer: interval, event select and disable ports.
//
// Operation
// - Interval port write sets countdown start value.
// - Interval is one byte, at most 255.
// - 1-127 seconds; 129-255 minutes from low bits.
// - Event select: reset, IRQ10/15/11, or NMI.
// - Any disable port write stops the countdown.
// - Interval port access while idle reloads counter and arms.
// - Expiry resets processor or raises selected interrupt.
`include "wdt_params.svh"
`default_nettype none

module wdt_io_watchdog #(
	parameter int TICK_CYCLES = `WDT_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire wdt_pkg::wdt_io_req_t io_req,
	output logic [7:0] io_rdata,
	output wdt_pkg::wdt_evt_t evt,
	output logic running
);

	// ======================================================================
	// Helpers
	function automatic logic addr_hit(input logic [15:0] a,
		input logic [15:0] port);
		addr_hit = (a == port);
	endfunction

	function automatic logic last_sec(input logic [5:0] s);
		last_sec = (s == `WDT_SEC_PER_MIN_LAST);
	endfunction

	function automatic wdt_pkg::wdt_evt_t evt_decode(input logic [2:0] sel);
		wdt_pkg::wdt_evt_t e;
		e = '0;
		if (sel == `WDT_SEL_RESET) begin
			e.sys_reset = 1'b1;
		end else if (sel == `WDT_SEL_IRQ10) begin
			e.irq10 = 1'b1;
		end else if (sel == `WDT_SEL_IRQ15) begin
			e.irq15 = 1'b1;
		end else if (sel == `WDT_SEL_IRQ11) begin
			e.irq11 = 1'b1;
		end else if (sel == `WDT_SEL_NMI) begin
			e.nmi = 1'b1;
		end
		evt_decode = e;
	endfunction

	// ======================================================================
	// Port decode
	wdt_pkg::wdt_state_t state_r, state_nxt;
	logic hit_int, hit_sel, hit_dis;
	logic arm_req, dis_req, arm_go;

	// The three ports never share an address, so at most one hit is set.
	always_comb begin
		hit_int = 1'b0;
		hit_sel = 1'b0;
		hit_dis = 1'b0;
		if (addr_hit(io_req.addr, `WDT_ADDR_INTERVAL)) begin
			hit_int = 1'b1;
		end else if (addr_hit(io_req.addr, `WDT_ADDR_EVSEL)) begin
			hit_sel = 1'b1;
		end else if (addr_hit(io_req.addr, `WDT_ADDR_DISABLE)) begin
			hit_dis = 1'b1;
		end
	end

	assign arm_req = hit_int && (io_req.wr || io_req.rd);
	assign dis_req = hit_dis && io_req.wr;

	// Only an idle timer is armed, and a disable in the same cycle wins.
	// Interval accesses while counting must not restart the divider
	// either, or polling that port would keep delaying expiry and act
	// as a refresh that skips the disable.
	assign arm_go = arm_req && !dis_req &&
		(state_r == wdt_pkg::WDT_IDLE);

	// ======================================================================
	// Registers
	logic [7:0] interval_r, interval_nxt;
	logic [2:0] evsel_r, evsel_nxt;
	logic [7:0] rdata_r, rdata_nxt;

	always_comb begin
		interval_nxt = interval_r;
		evsel_nxt = evsel_r;
		rdata_nxt = `WDT_RDATA_IDLE;
		if (io_req.wr && hit_int) begin
			interval_nxt = io_req.wdata;
		end
		// Codes above the NMI code are kept but fire nothing.
		if (io_req.wr && hit_sel) begin
			evsel_nxt = io_req.wdata[2:0];
		end
		// A read returns the stored byte, also in the cycle in which
		// that same read arms the timer.
		if (io_req.rd && hit_int) begin
			rdata_nxt = interval_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			interval_r <= `WDT_INTERVAL_RST;
			evsel_r <= `WDT_EVSEL_RST;
			rdata_r <= `WDT_RDATA_IDLE;
		end else begin
			interval_r <= interval_nxt;
			evsel_r <= evsel_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign io_rdata = rdata_r;

	// ======================================================================
	// Tick source
	logic sec_tick;
	logic div_clr;

	assign div_clr = arm_go || dis_req;

	wdt_tick_div #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk(clk),
		.rst(rst),
		.clr(div_clr),
		.tick(sec_tick)
	);

	// ======================================================================
	// Countdown
	logic [6:0] count_r, count_nxt;
	logic minutes_r, minutes_nxt;
	logic [5:0] sec_r, sec_nxt;
	logic unit_tick;
	wdt_pkg::wdt_evt_t evt_r, evt_nxt;

	// In minutes mode one count is sixty one-second ticks.
	assign unit_tick = sec_tick &&
		(!minutes_r || last_sec(sec_r));

	always_comb begin
		state_nxt = state_r;
		count_nxt = count_r;
		minutes_nxt = minutes_r;
		sec_nxt = sec_r;
		evt_nxt = '0;
		case (state_r)
			wdt_pkg::WDT_IDLE: begin
				// A write in the arming cycle is already the start value.
				if (arm_go) begin
					count_nxt = interval_nxt[6:0];
					minutes_nxt = interval_nxt[`WDT_UNIT_BIT];
					sec_nxt = '0;
					state_nxt = wdt_pkg::WDT_RUN;
				end
			end
			wdt_pkg::WDT_RUN: begin
				// Accesses while running do not refresh; software must
				// disable first.
				if (dis_req) begin
					state_nxt = wdt_pkg::WDT_IDLE;
				end else if (sec_tick) begin
					if (last_sec(sec_r)) begin
						sec_nxt = '0;
					end else begin
						sec_nxt = sec_r + 6'h01;
					end
					if (unit_tick) begin
						// A start value of zero has nothing left to count
						// and expires at the first unit, like one.
						if (count_r <= 7'h01) begin
							count_nxt = 7'h00;
							evt_nxt = evt_decode(evsel_r);
							state_nxt = wdt_pkg::WDT_EXPIRED;
						end else begin
							count_nxt = count_r - 7'h01;
						end
					end
				end
			end
			wdt_pkg::WDT_EXPIRED: begin
				if (dis_req) begin
					state_nxt = wdt_pkg::WDT_IDLE;
				end
			end
			default: begin
				state_nxt = wdt_pkg::WDT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= wdt_pkg::WDT_IDLE;
			count_r <= 7'h00;
			minutes_r <= 1'b0;
			sec_r <= 6'h00;
			evt_r <= '0;
		end else begin
			state_r <= state_nxt;
			count_r <= count_nxt;
			minutes_r <= minutes_nxt;
			sec_r <= sec_nxt;
			evt_r <= evt_nxt;
		end
	end

	assign evt = evt_r;
	assign running = (state_r == wdt_pkg::WDT_RUN);

endmodule // wdt_io_watchdog

`default_nettype wire

// ==== wdt_io_watchdog_sva.sv ====
// Assertion checker for the I/O port watchdog timer.
`default_nettype none
module wdt_io_watchdog_sva #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire wdt_pkg::wdt_io_req_t io_req,
	input wire logic [7:0] io_rdata,
	input wire wdt_pkg::wdt_evt_t evt,
	input wire logic running
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// Helpers
	localparam int HI = TICK_CYCLES - 5;
	logic [7:0] iv_r;
	logic [7:0] iv_nxt;
	logic [2:0] sel_r;
	logic [2:0] sel_nxt;
	logic rd_iv;
	assign rd_iv = io_req.rd && io_req.addr == 16'h0443;
	always_comb begin
		iv_nxt = iv_r;
		sel_nxt = sel_r;
		if (io_req.wr && io_req.addr == 16'h0443)
			iv_nxt = io_req.wdata;
		if (io_req.wr && io_req.addr == 16'h0444)
			sel_nxt = io_req.wdata[2:0];
	end
	always_ff @(posedge clk) begin
		iv_r <= rst ? 8'h00 : iv_nxt;
		sel_r <= rst ? 3'h0 : sel_nxt;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_dis;
		io_req.wr && io_req.addr == 16'h0080;
	endsequence
	sequence s_arm;
		io_req.wr && io_req.addr == 16'h0443;
	endsequence
	sequence s_arm1;
		io_req.wr && io_req.addr == 16'h0443 && io_req.wdata == 8'h01;
	endsequence
	// ==========
	// Properties
	a_disable_stops: assert property (s_dis |=> !running [*2])
		else $error("running after disable");
	a_rearm_runs: assert property (s_dis ##2 s_arm |=> running)
		else $error("no run after arm");
	a_one_sec: assert property (s_dis ##2 s_arm1
		|=> (evt == '0 && running) [*8] ##[1:HI] evt != '0)
		else $error("one second expiry off");
	a_read_back: assert property (rd_iv && !io_req.wr |=> io_rdata == iv_r)
		else $error("interval readback wrong");
	a_read_idle: assert property (!rd_iv |=> io_rdata == 8'h00)
		else $error("read data not idle");
	a_evt_onehot: assert property ($onehot0(evt))
		else $error("several events at once");
	a_evt_once: assert property (evt != '0 |=> evt == '0 && !running)
		else $error("event repeated");
	a_evt_cause: assert property (evt != '0 |-> $past(running))
		else $error("event while stopped");
	// Codes above the last action shift the one out and so fire nothing.
	a_evt_select: assert property (evt != '0 |->
		evt == (5'h10 >> $past(sel_r)))
		else $error("event differs from selection");
endmodule // wdt_io_watchdog_sva
bind wdt_io_watchdog wdt_io_watchdog_sva #(.TICK_CYCLES(TICK_CYCLES))
	wdt_io_watchdog_sva_inst (.clk(clk), .rst(rst), .io_req(io_req),
	.io_rdata(io_rdata), .evt(evt), .running(running));
`default_nettype wire

// ==== wdt_host_model.sv ====
// Host software model making byte I/O port accesses.
`default_nettype none
module wdt_host_model (
	input wire logic clk,
	input wire logic [7:0] io_rdata,
	output wdt_pkg::wdt_io_req_t io_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial io_req = '0;
	// ==========
	// Accesses
	// A released bus shows inverted values so stale data never passes.
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		io_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		io_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		#1 q = io_rdata;
	endtask
	task automatic arm(input logic [7:0] iv);
		logic [7:0] q;
		acc(1'b1, 16'h0080, 8'h00, q);
		acc(1'b1, 16'h0443, iv, q);
	endtask
endmodule // wdt_host_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking testbench of the I/O port watchdog timer.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] io_rdata;
	logic running;
	wdt_pkg::wdt_io_req_t io_req;
	wdt_pkg::wdt_evt_t evt;
	int err_count = 0;
	int samples_checked = 0;
	int seed = 32'h71e33610;
	localparam int TICKS = 10;
	always #25 clk = ~clk;
	wdt_io_watchdog #(.TICK_CYCLES(TICKS)) wdt_io_watchdog_inst (.clk(clk),
		.rst(rst), .io_req(io_req), .io_rdata(io_rdata), .evt(evt),
		.running(running));
	wdt_host_model wdt_host_model_inst (.clk(clk), .io_rdata(io_rdata),
		.io_req(io_req));
	// ==========
	// Tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		wdt_host_model_inst.acc(1'b1, a, d, q);
	endtask
	task automatic run(input int c, input logic [7:0] iv);
		int n;
		int e;
		logic [7:0] q;
		n = 0;
		e = (iv[7] ? 60 * iv[6:0] : iv) * TICKS + 1;
		wr(16'h0444, 8'(c));
		if (c % 2 == 1) begin
			// Odd runs arm by a read; the write only stores while expired.
			wr(16'h0443, iv);
			wr(16'h0080, 8'h00);
			wdt_host_model_inst.acc(1'b0, 16'h0443, 8'h00, q);
			check(q, iv);
		end else begin
			wdt_host_model_inst.arm(iv);
		end
		if (iv != 8'h01) begin
			repeat (3) @(posedge clk);
			wdt_host_model_inst.arm(iv);
		end
		while (evt === 5'h00 && n < 1000) begin
			@(posedge clk);
			#1 n++;
		end
		check(8'(n >= e - 1 && n <= e + 1), 8'h01);
		check({3'h0, evt}, 8'h10 >> c);
		wdt_host_model_inst.acc(1'b0, 16'h0443, 8'h00, q);
		repeat (30) @(posedge clk);
		check({7'h0, running}, 8'h00);
	endtask
	// ==========
	// Sequence
	initial begin
		logic [7:0] q;
		logic [7:0] r;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int c = 0; c < 5; c++)
			run(c, c == 0 ? 8'h01 : c == 4 ? 8'h81 :
				8'(1 + {$random(seed)} % 3));
		wdt_host_model_inst.arm(8'h02);
		repeat (15) @(posedge clk);
		wr(16'h0080, 8'($random(seed)));
		repeat (25) begin
			@(posedge clk);
			#1 check({2'h0, running, evt}, 8'h00);
		end
		q = 8'($random(seed));
		wr(16'h0443, q);
		wdt_host_model_inst.acc(1'b0, 16'h0443, 8'h00, r);
		check(r, q);
		wdt_host_model_inst.acc(1'b0, 16'h0444, 8'h00, r);
		check(r, 8'h00);
		wr(16'h0080, 8'h00);
		// A reset in mid-count stops the timer and clears both ports, so
		// a read then arms with a zero interval and the reset action.
		wdt_host_model_inst.arm(8'h03);
		repeat (5) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 check({2'h0, running, evt}, 8'h00);
		check(io_rdata, 8'h00);
		wdt_host_model_inst.acc(1'b0, 16'h0443, 8'h00, r);
		check(r, 8'h00);
		repeat (TICKS + 1) @(posedge clk);
		#1 check({3'h0, evt}, 8'h10);
		close_out();
	end
	initial begin
		#1000000;
		err_count++;
		close_out();
	end
endmodule // tb
`default_nettype wire
